// ---- nvmah_ctrl.sv ----
// AHB-Lite register slave for the NVM address-high byte and access-control fields,
// issuing latch loads and write starts to the programming engine.
// Assumes a single AHB-Lite master, word transfers, and an engine that pulses op_done.
//
// Summary of operation
// - Address-high bit 7 is unimplemented: reads one, writes ignored.
// - Address-high bits 6..0 hold address bits 14..8 for flash and EEPROM.
// - Latch-only applies in config space, or normal space with flash selected.
// - Latch-only set: write command loads latches only, no programming started.
// - Latch-only clear: write command loads data pair into latches and starts programming in the same cycle.
// - Implemented address-high bits reset to zero on every reset.
// - Config select set targets user ID, device ID and configuration words.
// - EEPROM selected: latch-only ignored, write command starts EEPROM write.
// - Program enable already clear before the command write blocks all programming and erasing.
`timescale 1ns/1ps
`include "nvmah_defines.svh"

module nvmah_ctrl
	import nvmah_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic op_done,
	output logic latch_load,
	output nvmah_latch_s latch_word,
	output logic program_start,
	output logic eeprom_write_start,
	output nvmah_space_e target_space,
	output logic [14:0] nvm_address
);

	function automatic logic hit(input logic [7:0] ofs, input logic [7:0] reg_ofs);
		hit = (ofs == reg_ofs);
	endfunction

	function automatic nvmah_space_e space_of(input logic cfg, input logic flash);
		if (cfg)
			space_of = space_config;
		else if (flash)
			space_of = space_flash;
		else
			space_of = space_eeprom;
	endfunction

	nvmah_aphase_s ap;
	nvmah_state_e state;
	nvmah_state_e next_state;
	logic [6:0] addr_high;
	logic [7:0] addr_low;
	logic [7:0] data_low;
	logic [5:0] data_high;
	logic space_select_flash;
	logic config_space_select;
	logic latch_only_load;
	logic program_enable;

	// Word size only; other sizes are accepted and treated as a full word
	wire unused_size = |hsize;
	wire ap_take = hready;
	wire ap_active = hsel & htrans[`NVMAH_HTRANS_BIT_ACTIVE];
	wire wr_phase = ap.valid & ap.write;
	wire wr_addr_high = wr_phase & hit(ap.offset, `NVMAH_OFS_ADDR_HIGH);
	wire wr_ctrl = wr_phase & hit(ap.offset, `NVMAH_OFS_ACCESS_CTRL);
	wire wr_addr_low = wr_phase & hit(ap.offset, `NVMAH_OFS_ADDR_LOW);
	wire wr_data_low = wr_phase & hit(ap.offset, `NVMAH_OFS_DATA_LOW);
	wire wr_data_high = wr_phase & hit(ap.offset, `NVMAH_OFS_DATA_HIGH);

	// Fields as they stand after this write, so space and command may share one write
	wire new_flash = hwdata[`NVMAH_BIT_FLASH];
	wire new_config = hwdata[`NVMAH_BIT_CONFIG];
	wire new_latch_only = hwdata[`NVMAH_BIT_LATCH_ONLY];
	wire new_space_eeprom = (space_of(new_config, new_flash) == space_eeprom);
	// Enable must already be set before the command write
	wire cmd_go = wr_ctrl & hwdata[`NVMAH_BIT_WRITE_CMD] & program_enable
		& (state == st_idle);
	wire go_eeprom = cmd_go & new_space_eeprom;
	wire go_latch_only = cmd_go & ~new_space_eeprom & new_latch_only;
	wire go_program = cmd_go & ~new_space_eeprom & ~new_latch_only;
	wire write_cmd_busy = (state != st_idle);

	wire [7:0] rd_ofs = haddr[7:0];
	wire [7:0] addr_high_view = `NVMAH_ADDRH_FILL | {1'b0, addr_high};
	wire [7:0] ctrl_view = {space_select_flash, config_space_select, latch_only_load,
		2'b00, program_enable, write_cmd_busy, 1'b0};
	wire [7:0] status_view = {2'b00, target_space, 2'b00, state};
	logic [31:0] next_rdata;

	always_comb
	begin
		if (hit(rd_ofs, `NVMAH_OFS_ADDR_HIGH))
			next_rdata = {24'h000000, addr_high_view};
		else if (hit(rd_ofs, `NVMAH_OFS_ACCESS_CTRL))
			next_rdata = {24'h000000, ctrl_view};
		else if (hit(rd_ofs, `NVMAH_OFS_ADDR_LOW))
			next_rdata = {24'h000000, addr_low};
		else if (hit(rd_ofs, `NVMAH_OFS_DATA_LOW))
			next_rdata = {24'h000000, data_low};
		else if (hit(rd_ofs, `NVMAH_OFS_DATA_HIGH))
			next_rdata = {26'h0000000, data_high};
		else if (hit(rd_ofs, `NVMAH_OFS_STATUS))
			next_rdata = {24'h000000, status_view};
		else
			next_rdata = `NVMAH_RDATA_NONE;
	end

	always_comb
	begin
		next_state = state;
		case (state)
			st_idle:
			begin
				if (go_eeprom || go_program)
					next_state = st_busy;
				else if (go_latch_only)
					next_state = st_latch;
			end
			st_latch:
				next_state = st_idle;
			st_busy:
			begin
				if (op_done)
					next_state = st_idle;
			end
			default:
				next_state = st_idle;
		endcase
	end

	assign hreadyout = 1'b1;
	assign hresp = `NVMAH_HRESP_OKAY;
	assign nvm_address = {addr_high, addr_low};
	assign target_space = space_of(config_space_select, space_select_flash);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ap <= '0;
			hrdata <= `NVMAH_RDATA_NONE;
		end
		else if (ap_take)
		begin
			ap <= '{valid: ap_active, write: hwrite, offset: haddr[7:0]};
			hrdata <= (ap_active && !hwrite) ? next_rdata : `NVMAH_RDATA_NONE;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			addr_high <= `NVMAH_ADDRH_RESET;
		else if (wr_addr_high)
			addr_high <= hwdata[6:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			addr_low <= `NVMAH_ADDRL_RESET;
			data_low <= `NVMAH_DATA_RESET;
			data_high <= '0;
		end
		else
		begin
			if (wr_addr_low)
				addr_low <= hwdata[7:0];
			if (wr_data_low)
				data_low <= hwdata[7:0];
			if (wr_data_high)
				data_high <= hwdata[5:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			space_select_flash <= 1'b0;
			config_space_select <= 1'b0;
			latch_only_load <= 1'b0;
			program_enable <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			space_select_flash <= new_flash;
			config_space_select <= new_config;
			latch_only_load <= new_latch_only;
			program_enable <= hwdata[`NVMAH_BIT_PROG_EN];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state <= st_idle;
			latch_load <= 1'b0;
			program_start <= 1'b0;
			eeprom_write_start <= 1'b0;
			latch_word <= '0;
		end
		else
		begin
			state <= next_state;
			latch_load <= go_latch_only | go_program;
			program_start <= go_program;
			eeprom_write_start <= go_eeprom;
			if (go_latch_only || go_program)
				latch_word <= '{addr: nvm_address, data: {data_high, data_low}};
		end
	end

endmodule // nvmah_ctrl

// ---- nvmah_defines.svh ----
// Register offsets, field positions, reset values of the NVM address-high/control block.
// Included by the design; definitions only.
`ifndef NVMAH_DEFINES_SVH
`define NVMAH_DEFINES_SVH

`define NVMAH_OFS_ADDR_HIGH 8'h00
`define NVMAH_OFS_ACCESS_CTRL 8'h04
`define NVMAH_OFS_ADDR_LOW 8'h08
`define NVMAH_OFS_DATA_LOW 8'h0c
`define NVMAH_OFS_DATA_HIGH 8'h10
`define NVMAH_OFS_STATUS 8'h14

`define NVMAH_ADDRH_FILL 8'h80
`define NVMAH_ADDRH_RESET 7'h00
`define NVMAH_ADDRL_RESET 8'h00
`define NVMAH_DATA_RESET 8'h00
`define NVMAH_STATUS_IDLE_CONFIG 32'h0000_0020

`define NVMAH_BIT_FLASH 7
`define NVMAH_BIT_CONFIG 6
`define NVMAH_BIT_LATCH_ONLY 5
`define NVMAH_BIT_PROG_EN 2
`define NVMAH_BIT_WRITE_CMD 1

`define NVMAH_HTRANS_BIT_ACTIVE 1
`define NVMAH_HRESP_OKAY 1'b0
`define NVMAH_RDATA_NONE 32'h0000_0000

`endif

// ---- nvmah_monitor.sv ----
// Port checker for nvmah_ctrl.
// Assumes one master and hready tied to hreadyout.
`timescale 1ns/1ps
module nvmah_monitor
	import nvmah_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic latch_load,
	input wire nvmah_latch_s latch_word,
	input wire logic program_start,
	input wire logic eeprom_write_start,
	input wire nvmah_space_e target_space,
	input wire logic [14:0] nvm_address
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic dw, rh, pen;
	logic [7:0] da;
	logic [2:0] ctl;
	wire tk = hsel && hready && htrans[1];
	wire wc = dw && da == 8'h04;
	// Shadow fields move at the data-phase edge, like the slave
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			{dw, rh, pen, da, ctl} <= '0;
		else
		begin
			dw <= tk && hwrite;
			rh <= tk && !hwrite && haddr[7:0] == 8'h00;
			da <= haddr[7:0];
			if (wc)
				{ctl, pen} <= {hwdata[7:5], hwdata[2]};
		end
	end
	AST_TOP_ONE: assert property
		(rh |-> hrdata[7:0] == {1'h1, nvm_address[14:8]}) else $error("high read");
	AST_HIGH_LOAD: assert property
		(dw && da == 8'h00 |=> nvm_address[14:8] == $past(hwdata[6:0])) else $error("high load");
	AST_RESET_ZERO: assert property
		($rose(hresetn) |-> nvm_address == 15'h0) else $error("reset value");
	AST_SPACE: assert property
		(target_space == (ctl[1] ? space_config : ctl[2] ? space_flash : space_eeprom))
		else $error("space");
	AST_LATCH_ONLY: assert property
		(latch_load |-> program_start == !ctl[0]) else $error("latch only");
	AST_EE_START: assert property
		(eeprom_write_start |-> !latch_load && target_space == space_eeprom) else $error("ee");
	AST_LATCH_WORD: assert property
		(latch_load |-> target_space != space_eeprom && latch_word.addr == nvm_address)
		else $error("latch word");
	AST_ENABLED: assert property
		(latch_load || eeprom_write_start |-> $past(pen) && $past(wc)) else $error("enable");
endmodule // nvmah_monitor
bind nvmah_ctrl nvmah_monitor nvmah_monitor_i (.*);

// ---- nvmah_pkg.sv ----
// Types shared by the NVM address-high/control block.
// Assumes nvmah_defines.svh is on the include path.
package nvmah_pkg;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_latch = 2'b01,
		st_busy = 2'b10
	} nvmah_state_e;

	typedef enum logic [1:0] {
		space_eeprom = 2'b00,
		space_flash = 2'b01,
		space_config = 2'b10
	} nvmah_space_e;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] offset;
	} nvmah_aphase_s;

	typedef struct packed {
		logic [14:0] addr;
		logic [13:0] data;
	} nvmah_latch_s;

endpackage

// ---- testbench.sv ----
// Self-checking bench for nvmah_ctrl.
// Assumes nvmah_monitor is bound to the design.
`timescale 1ns/1ps
module testbench;
	logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, op_done = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, s = 32'h16, dl, dh, ah;
	logic [8:0] seen = 9'h0, base;
	logic [2:0] e;
	wire hreadyout, hresp, latch_load, program_start, eeprom_write_start;
	wire hready = hreadyout;
	wire [31:0] hrdata;
	wire [28:0] latch_word;
	wire [1:0] target_space;
	wire [14:0] nvm_address;
	int failures = 0, check_count = 0;
	nvmah_ctrl nvmah_ctrl_i (.*);
	initial forever #5 hclk = ~hclk;
	// Three-bit count per pulse so a doubled pulse shows
	always @(posedge hclk) seen <= seen + {latch_load, 2'h0, program_start, 2'h0, eeprom_write_start};
	function automatic logic [31:0] xs();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	// Pulses {latch, program, eeprom} for {enable, flash, config, latch only}
	function automatic logic [2:0] ex(input logic [3:0] i);
		if (!i[3])
			return 3'h0;
		if (i[2] || i[1])
			return {1'h1, !i[0], 1'h0};
		return 3'h1;
	endfunction
	task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (g !== x)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic rdy();
		@(posedge hclk);
		for (int n = 0; hready !== 1'h1; n++)
		begin
			if (n > 16)
			begin
				failures++;
				close_out();
			end
			@(posedge hclk);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		rdy();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		rd = hrdata;
		cmp("hresp", 32'h0, {31'h0, hresp});
	endtask
	initial
	begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'h1;
		bus(1'h0, 8'h00, 32'h0);
		cmp("addr_high", 32'h80, rd);
		$display("end reset");
		repeat (8)
		begin
			ah = xs();
			bus(1'h1, 8'h00, ah);
			bus(1'h0, 8'h00, 32'h0);
			cmp("addr_high", {24'h0, 1'h1, ah[6:0]}, rd);
		end
		bus(1'h1, 8'h18, xs());
		bus(1'h0, 8'h18, 32'h0);
		cmp("unmapped", 32'h0, rd);
		$display("end address");
		for (int i = 0; i < 16; i++)
		begin
			dl = xs();
			dh = xs();
			e = ex(i[3:0]);
			bus(1'h1, 8'h08, dl);
			bus(1'h1, 8'h0c, dl);
			bus(1'h1, 8'h10, dh);
			bus(1'h1, 8'h04, {29'h0, i[3], 2'h0});
			base = seen;
			bus(1'h1, 8'h04, {24'h0, i[2:0], 2'h0, i[3], 2'h2});
			repeat (3) @(posedge hclk);
			cmp("pulses", {2'h0, e[2], 2'h0, e[1], 2'h0, e[0]}, seen - base);
			cmp("space", i[1] ? 32'h2 : i[2] ? 32'h1 : 32'h0, target_space);
			if (e[2])
				cmp("latch_word", {ah[6:0], dl[7:0], dh[5:0], dl[7:0]}, latch_word);
			op_done <= 1'h1;
			@(posedge hclk);
			op_done <= 1'h0;
			bus(1'h0, 8'h04, 32'h0);
			cmp("control", {i[2:0], 2'h0, i[3], 2'h0}, rd & 32'he6);
		end
		bus(1'h0, 8'h14, 32'h0);
		cmp("status", 32'h20, rd);
		$display("end commands");
		bus(1'h1, 8'h00, 32'h7f);
		hresetn <= 1'h0;
		@(posedge hclk);
		hresetn <= 1'h1;
		bus(1'h0, 8'h00, 32'h0);
		cmp("addr_high", 32'h80, rd);
		$display("end second reset");
		close_out();
	end
endmodule // testbench
